/* core/suc_counter.sv */
// APB-controlled synchronous 4-bit up/down counter, decade or binary
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module suc_counter
    import suc_pkg::*;
#(
    parameter bit DECADE = 1'b1
) (
    input wire logic pclk, // Bus and count clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address or write to a read-only register
    output logic [3:0] count_value, // Counter state
    output logic terminal_count_n // Terminal count, active low
);
    `include "suc_defines.svh"

    suc_ctrl_t ctrl;
    logic [3:0] preset_value;
    logic [3:0] next_count;
    suc_ctrl_t next_ctrl;
    logic [3:0] next_preset;
    logic [31:0] next_rdata;
    suc_action_t action;

    // Bus phase decode
    wire logic setup_ph = psel & ~penable;
    wire logic access_done = psel & penable & pready;
    wire logic wr_done = access_done & pwrite & ~pslverr;
    wire logic sel_ctrl = (paddr == `SUC_CTRL_OFS);
    wire logic sel_preset = (paddr == `SUC_PRESET_OFS);
    wire logic sel_status = (paddr == `SUC_STATUS_OFS);
    wire logic sel_info = (paddr == `SUC_INFO_OFS);
    wire logic mapped = sel_ctrl | sel_preset | sel_status | sel_info;
    wire logic ro_write = pwrite & (sel_status | sel_info);

    // Register write values, byte lane 0 only
    assign next_ctrl = (wr_done & sel_ctrl & pstrb[0]) ?
                       suc_ctrl_t'(pwdata[`SUC_CTRL_W-1:0]) : ctrl;
    assign next_preset = (wr_done & sel_preset & pstrb[0]) ? pwdata[3:0] : preset_value;

    // Read mux
    assign next_rdata = sel_ctrl ? {28'h0000000, ctrl} :
                        sel_preset ? {28'h0000000, preset_value} :
                        sel_status ? {27'h0000000, terminal_count_n, count_value} :
                        sel_info ? {31'h00000000, DECADE} : 32'h00000000;

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= suc_ctrl_t'(`SUC_CTRL_RST);
            preset_value <= `SUC_PRESET_RST;
        end else begin
            ctrl <= next_ctrl;
            preset_value <= next_preset;
        end
    end

    // One wait-free access: answer prepared in setup, shown in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (setup_ph) begin
            pready <= 1'b1;
            pslverr <= ~mapped | ro_write;
            prdata <= pwrite ? 32'h00000000 : next_rdata;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    suc_next #(
        .DECADE(DECADE)
    ) u_next (
        .count_value(count_value),
        .preset_value(preset_value),
        .ctrl(ctrl),
        .next_count(next_count),
        .action(action)
    );

    // Counter stages, edge sampled, deliberately without reset
    always_ff @(posedge pclk) begin
        count_value <= next_count;
    end

    // Combinational lookahead decode for cascading; not for clocking
    suc_tc #(
        .DECADE(DECADE)
    ) u_tc (
        .count_value(count_value),
        .up_down(ctrl.up_down),
        .trickle_count_enable_n(ctrl.trickle_count_enable_n),
        .terminal_count_n(terminal_count_n)
    );
endmodule
`default_nettype wire

/* core/suc_defines.svh */
// Register map, field positions, reset values and widths of the up/down counter
`ifndef SUC_DEFINES_SVH
`define SUC_DEFINES_SVH

// Register byte offsets
`define SUC_CTRL_OFS 12'h000
`define SUC_PRESET_OFS 12'h004
`define SUC_STATUS_OFS 12'h008
`define SUC_INFO_OFS 12'h00c

// Address bits decoded by the slave
`define SUC_ADDR_W 12

// Counter width and extreme values
`define SUC_WIDTH 4
`define SUC_ZERO 4'h0
`define SUC_DEC_MAX 4'h9
`define SUC_BIN_MAX 4'hf

// Control field positions
`define SUC_CTRL_LOAD_BIT 0
`define SUC_CTRL_PAR_BIT 1
`define SUC_CTRL_TRK_BIT 2
`define SUC_CTRL_UP_BIT 3
`define SUC_CTRL_W 4

// Control reset value: load active, count enables off, direction up
`define SUC_CTRL_RST 4'he
`define SUC_PRESET_RST 4'h0

// Status field positions
`define SUC_STAT_TC_BIT 4

// Info field: variant flag
`define SUC_INFO_DEC_BIT 0

`endif

/* core/suc_pkg.sv */
// Types shared by the up/down counter files
package suc_pkg;

    // Control word as held in the control register
    typedef struct packed {
        logic up_down;
        logic trickle_count_enable_n;
        logic parallel_count_enable_n;
        logic load_enable_n;
    } suc_ctrl_t;

    // Action taken on the next clock edge
    typedef enum logic [1:0] {
        SUC_HOLD,
        SUC_LOAD,
        SUC_UP,
        SUC_DOWN
    } suc_action_t;

endpackage

/* core/suc_next.sv */
// Next-state logic of the counter stages
`timescale 1ns/100ps
`default_nettype none
module suc_next
    import suc_pkg::*;
#(
    parameter bit DECADE = 1'b1
) (
    input wire logic [3:0] count_value, // Present state
    input wire logic [3:0] preset_value, // Parallel data
    input wire suc_ctrl_t ctrl, // Control inputs
    output logic [3:0] next_count, // State after the edge
    output suc_action_t action // Chosen action
);
    `include "suc_defines.svh"

    // Wrap limits per variant
    localparam logic [3:0] MAX_VAL = DECADE ? `SUC_DEC_MAX : `SUC_BIN_MAX;

    // Load first, then count only with both enables low
    wire logic count_en = ~ctrl.parallel_count_enable_n & ~ctrl.trickle_count_enable_n;
    wire logic at_or_above_max = (count_value >= MAX_VAL);
    wire logic above_max = (count_value > MAX_VAL);

    // Action select
    assign action = ~ctrl.load_enable_n ? SUC_LOAD :
                    ~count_en ? SUC_HOLD :
                    ctrl.up_down ? SUC_UP : SUC_DOWN;

    // Next value per action, illegal decade states return in one step when counting up or down
    always_comb begin
        case (action)
            SUC_LOAD: next_count = preset_value;
            SUC_UP: next_count = at_or_above_max ? `SUC_ZERO : count_value + 4'h1;
            SUC_DOWN: begin
                if (count_value == `SUC_ZERO || above_max) begin
                    next_count = MAX_VAL;
                end else begin
                    next_count = count_value - 4'h1;
                end
            end
            default: next_count = count_value;
        endcase
    end
endmodule
`default_nettype wire

/* core/suc_tc.sv */
// Terminal-count decode of the counter state
`timescale 1ns/100ps
`default_nettype none
module suc_tc
#(
    parameter bit DECADE = 1'b1
) (
    input wire logic [3:0] count_value, // Present state
    input wire logic up_down, // High counts up
    input wire logic trickle_count_enable_n, // Trickle enable, active low
    output logic terminal_count_n // Terminal count, active low
);
    // Up decode: decade hits nine only, binary hits fifteen
    wire logic up_hit = DECADE ?
        (count_value[0] & ~count_value[1] & ~count_value[2] & count_value[3]) :
        (&count_value);
    wire logic down_hit = ~|count_value;

    // No dependence on the parallel enable
    assign terminal_count_n = ~(~trickle_count_enable_n &
                                (up_down ? up_hit : down_hit));
endmodule
`default_nettype wire

/* verification/suc_assertions.sv */
// Checker for the APB side and counting of the up/down counter
`timescale 1ns/100ps
`default_nettype none
module suc_assertions (
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr, terminal_count_n,
    input wire logic [11:0] paddr, // Byte address
    input wire logic [31:0] pwdata, prdata, // Bus data
    input wire logic [3:0] pstrb, count_value // Strobes, state
);
    logic [3:0] ctrl;
    logic [3:0] pre;
    wire wr = psel & penable & pready & pwrite & pstrb[0];
    wire cnt = ctrl[0] & !ctrl[1] & !ctrl[2];
    wire tc = !ctrl[2] & (ctrl[3] ? count_value == 4'h9 : count_value == 4'h0);
    // Shadow copies of control and preset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 4'he;
            pre <= 4'h0;
        end else if (wr && paddr == 12'h000) begin
            ctrl <= pwdata[3:0];
        end else if (wr && paddr == 12'h004) begin
            pre <= pwdata[3:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s; psel && !penable; endsequence
    ready_after_setup_a: assert property (setup_s |=> pready ##1 !pready) else $error("bad ready");
    idle_rdata_a: assert property (!pready |-> prdata == 32'h0) else $error("read data not zero");
    unmapped_err_a: assert property (psel && !penable && paddr > 12'h00c |=> pslverr) else $error("no error");
    load_copy_a: assert property (!ctrl[0] |=> count_value == $past(pre)) else $error("load");
    count_up_a: assert property (cnt && ctrl[3] && count_value < 4'h9 |=> count_value == $past(count_value) + 4'h1) else $error("up");
    count_down_a: assert property (cnt && !ctrl[3] && count_value inside {[1:9]} |=> count_value == $past(count_value) - 4'h1) else $error("down");
    wrap_ends_a: assert property (cnt && count_value == (ctrl[3] ? 4'h9 : 4'h0) |=> count_value == (ctrl[3] ? 4'h0 : 4'h9)) else $error("wrap");
    hold_state_a: assert property (ctrl[0] && (ctrl[1] || ctrl[2]) |=> $stable(count_value)) else $error("hold");
    illegal_back_a: assert property (cnt && count_value > 4'h9 |-> ##[1:2] count_value <= 4'h9) else $error("illegal");
    tc_decode_a: assert property (count_value <= 4'h9 |-> terminal_count_n == !tc) else $error("tc");
endmodule
bind suc_counter suc_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .pslverr, .terminal_count_n, .paddr, .pwdata, .prdata, .pstrb, .count_value);
`default_nettype wire

/* verification/suc_next_stage.sv */
// Cascaded next stage taking the terminal count as its carry
`timescale 1ns/100ps
`default_nettype none
module suc_next_stage (
    input wire logic pclk, // Shared clock
    input wire logic terminal_count_n, // Carry in, active low
    output logic [7:0] carries // Carries seen
);
    // Carry sampled on the shared clock, never used as a clock
    initial carries = 8'h0;
    always @(posedge pclk) if (terminal_count_n === 1'b0) carries <= carries + 8'h1;
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Register-level test of the up/down counter
`timescale 1ns/100ps
`default_nettype none
`include "suc_defines.svh"
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, tc_n, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf, cnt;
    logic [7:0] carries;
    int err_count = 0, comparisons = 0;
    logic [3:0] mode[8] = '{4'h9, 4'h1, 4'h9, 4'h1, 4'hb, 4'h7, 4'h9, 4'h8};
    logic [3:0] pv[8] = '{4'h8, 4'h1, 4'h6, 4'h3, 4'h9, 4'hd, 4'hc, 4'h5};
    logic [3:0] hc[8] = '{4'hb, 4'h3, 4'hb, 4'h3, 4'hb, 4'h7, 4'hb, 4'hb};
    logic [4:0] ex[8] = '{5'h11, 5'h18, 5'h09, 5'h00, 5'h09, 5'h1d, 5'h12, 5'h15};
    suc_counter #(.DECADE(1'b1)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .count_value(cnt), .terminal_count_n(tc_n));
    suc_next_stage u_far (.pclk, .terminal_count_n(tc_n), .carries);
    initial forever #10 pclk = ~pclk;
    // One APB transfer, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        // A slave that never answers counts as a mismatch
        if (pready !== 1'b1) err_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        report_and_stop;
    end
    // Reset values, refusals, then load and count cases
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `SUC_CTRL_OFS, 32'h0);
        chk(rd, 32'he);
        apb(0, `SUC_PRESET_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(0, `SUC_INFO_OFS, 32'h0);
        chk(rd, 32'h1);
        apb(0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1, `SUC_STATUS_OFS, 32'h5);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            apb(1, `SUC_CTRL_OFS, 32'he);
            apb(1, `SUC_PRESET_OFS, {28'h0, pv[i]});
            apb(1, `SUC_CTRL_OFS, {28'h0, mode[i]});
            apb(1, `SUC_CTRL_OFS, {28'h0, hc[i]});
            apb(0, `SUC_STATUS_OFS, 32'h0);
            chk(rd, {27'h0, ex[i]});
        end
        chk({31'h0, carries != 8'h0}, 32'h1);
        report_and_stop;
    end
endmodule
`default_nettype wire
